// ---- verilog/dual_logic_pkg.sv ----
// constants shared by the dual programmable logic block and its cells
package dual_logic_pkg;

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] ADDR_BLOCK_ONE_CFG = 8'h44;
  localparam logic [7:0] ADDR_BLOCK_TWO_CFG = 8'h45;
  localparam logic [7:0] ADDR_FF_CONTROL    = 8'h46;
  localparam logic [7:0] ADDR_EVENT_ENABLE  = 8'h47;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] RESET_BLOCK_CFG    = 8'h00;
  localparam logic [3:0] RESET_FF_CONTROL   = 4'h0;
  localparam logic [5:0] RESET_EVENT_ENABLE = 6'h00;

  // ********************************************************************
  // block configuration fields
  // ********************************************************************
  localparam int SEL_LSB     = 0;
  localparam int SEL_MSB     = 2;
  localparam int INV_A_BIT   = 3;
  localparam int INV_B_BIT   = 4;
  localparam int INV_C_BIT   = 5;
  localparam int INV_Y_BIT   = 6;
  localparam int CHAIN_BIT   = 7;

  // flip-flop control fields
  localparam int FF1_CLEAR_BIT = 0;
  localparam int FIRST_FLIPFLOP_FORCE_SET_BIT   = 1;
  localparam int FF2_CLEAR_BIT = 2;
  localparam int SECOND_FLIPFLOP_FORCE_SET_BIT   = 3;

  // event enable fields
  localparam int EV1_LEVEL_BIT  = 0;
  localparam int EV1_ENABLE_BIT = 1;
  localparam int EV1_BYPASS_BIT = 2;
  localparam int EV2_LEVEL_BIT  = 3;
  localparam int EV2_ENABLE_BIT = 4;
  localparam int EV2_BYPASS_BIT = 5;

  // ********************************************************************
  // function select encodings
  // ********************************************************************
  localparam logic [2:0] FN_OFF   = 3'h0;
  localparam logic [2:0] FN_AND   = 3'h1;
  localparam logic [2:0] FN_OR    = 3'h2;
  localparam logic [2:0] FN_XOR   = 3'h3;
  localparam logic [2:0] FN_FLOP  = 3'h4;
  localparam logic [2:0] FN_PASSA = 3'h5;
  localparam logic [2:0] FN_PASSB = 3'h6;
  localparam logic [2:0] FN_PASSC = 3'h7;

  // row three alternate function code that routes the pin into input c
  localparam logic [1:0] ROW_THREE_LOGIC_C = 2'h1;

  // ********************************************************************
  // debounce timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS        = 5;
  localparam int DEBOUNCE_TICK_NS     = 1000;
  localparam int DEBOUNCE_TICK_CYCLES = (DEBOUNCE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_TICKS       = 4;

endpackage

// ---- verilog/logic_cell.sv ----
// one programmable logic cell: input inversion, function mux, flip-flop, debounce, events
`timescale 1ns/1ps
`default_nettype none

module logic_cell #(
  parameter int STABLE_TICKS = dual_logic_pkg::DEBOUNCE_TICKS
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] funcSel,
  input  wire logic       invA,
  input  wire logic       invB,
  input  wire logic       invC,
  input  wire logic       invY,
  input  wire logic       inA,
  input  wire logic       inB,
  input  wire logic       inC,
  input  wire logic       forceSet,
  input  wire logic       forceClear,
  input  wire logic       debounceBypass,
  input  wire logic       eventEnable,
  input  wire logic       activeHigh,
  input  wire logic       debounceTick,
  output logic            blockOut,
  output logic            filteredOut,
  output logic            eventPulse,
  output logic            eventActive
);

  localparam int CW = $clog2(STABLE_TICKS + 1);

  typedef struct packed {
    logic          prevB;
    logic          flop;
    logic          filt;
    logic [CW-1:0] count;
    logic          pulse;
    logic          active;
  } cell_s;

  cell_s st_r;
  cell_s st_nxt;
  logic  a;
  logic  b;
  logic  c;
  logic  yPre;

  // ********************************************************************
  // combinational function
  // ********************************************************************
  always_comb begin
    a = inA ^ invA;
    b = inB ^ invB;
    c = inC ^ invC;
    unique case (funcSel)
      dual_logic_pkg::FN_OFF:   yPre = 1'b0;
      dual_logic_pkg::FN_AND:   yPre = a & b & c;
      dual_logic_pkg::FN_OR:    yPre = a | b | c;
      dual_logic_pkg::FN_XOR:   yPre = a ^ b ^ c;
      dual_logic_pkg::FN_FLOP:  yPre = st_r.flop;
      dual_logic_pkg::FN_PASSA: yPre = a;
      dual_logic_pkg::FN_PASSB: yPre = b;
      dual_logic_pkg::FN_PASSC: yPre = c;
    endcase
    blockOut = yPre ^ invY;
  end

  // ********************************************************************
  // flip-flop, debounce and event detection
  // ********************************************************************
  always_comb begin
    st_nxt       = st_r;
    st_nxt.prevB = b;
    // capture and forces
    // capture a on rising b
    if (b && !st_r.prevB) begin
      st_nxt.flop = a;
    end
    // forced controls, clear wins
    if (forceClear) begin
      st_nxt.flop = 1'b0;
    end else if (forceSet) begin
      st_nxt.flop = 1'b1;
    end
    // filter: value must hold for the full tick count before it is taken
    if (debounceBypass) begin
      st_nxt.filt  = blockOut;
      st_nxt.count = '0;
    end else if (blockOut == st_r.filt) begin
      st_nxt.count = '0;
    end else if (debounceTick) begin
      if (st_r.count == CW'(STABLE_TICKS - 1)) begin
        st_nxt.filt  = blockOut;
        st_nxt.count = '0;
      end else begin
        st_nxt.count = st_r.count + CW'(1);
      end
    end
    // off cell silent
    // an off cell and a disabled cell raise no event pulse; eventActive still follows the filtered level
    st_nxt.pulse  = eventEnable && (funcSel != dual_logic_pkg::FN_OFF)
                    && (st_nxt.filt != st_r.filt);
    st_nxt.active = (st_nxt.filt == activeHigh);
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filteredOut = st_r.filt;
  assign eventPulse  = st_r.pulse;
  assign eventActive = st_r.active;

endmodule

`default_nettype wire

// ---- verilog/dual_programmable_logic.sv ----
// two programmable logic blocks with their registers, pin routing and event outputs
//
// Overview of operation
// - first block select: off, and, or, xor, flop, pass a, b, c
// - second block select uses the identical eight-code encoding
// - first block bits 3, 4, 5 invert inputs a, b, c
// - first block bit 6 inverts its output
// - second block bits 3, 4, 5 invert inputs a, b, c
// - second block bit 6 inverts its output
// - second block bit 7 feeds first output into its input a
// - chaining routes internally, row zero pin stays free
// - flop control bit 1 forces first flop set, bit 0 clears
// - flop control bit 3 forces second flop set, bit 2 clears
// - event bit 2 clear debounces first output, set bypasses
// - event bit 5 clear debounces second output, set bypasses
// - event bit 1 lets first output raise events, else none
// - event bit 4 lets second output raise events, else none
// - event bit 0 gives first output active level, one is high
// - event bit 3 gives second output active level, one is high
// - first input c from row three pin when its alt code is 01
// - first output drives row zero pin only when its alt bit set
// - second input c from column six pin when its alt bit set
// - second output drives column nine pin only when alt bit set
`timescale 1ns/1ps
`default_nettype none

module dual_programmable_logic #(
  parameter int TICK_CYCLES  = dual_logic_pkg::DEBOUNCE_TICK_CYCLES,
  parameter int STABLE_TICKS = dual_logic_pkg::DEBOUNCE_TICKS
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  input  wire logic       firstInputA,
  input  wire logic       firstInputB,
  input  wire logic       secondInputA,
  input  wire logic       secondInputB,
  input  wire logic       rowThreePinIn,
  input  wire logic       columnSixPinIn,
  input  wire logic [1:0] rowThreeAltFunction,
  input  wire logic       rowZeroAltFunction,
  input  wire logic       columnSixAltFunction,
  input  wire logic       columnNineAltFunction,
  output logic            rowZeroPinOut,
  output logic            rowZeroPinOeN,
  output logic            columnNinePinOut,
  output logic            columnNinePinOeN,
  output logic            firstBlockOutput,
  output logic            secondBlockOutput,
  output logic            firstEventPulse,
  output logic            firstEventActive,
  output logic            secondEventPulse,
  output logic            secondEventActive
);

  localparam int DW = $clog2(TICK_CYCLES + 1);

  // ********************************************************************
  // state of the top level
  // ********************************************************************
  typedef struct packed {
    logic [6:0]    cfgOne;
    logic [7:0]    cfgTwo;
    logic [3:0]    ffCtl;
    logic [5:0]    evtEn;
    logic [7:0]    rdData;
    logic          rdValid;
    logic [DW-1:0] divCount;
    logic          tick;
    logic          rowZeroOut;
    logic          rowZeroOeN;
    logic          colNineOut;
    logic          colNineOeN;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  // cell wiring
  logic firstY;
  logic secondY;
  logic firstFilt;
  logic secondFilt;
  logic firstInC;
  logic secondInA;
  logic secondInC;

  // ********************************************************************
  // input routing
  // ********************************************************************
  // pin inputs only reach the cells when the pin is given over to logic;
  // otherwise the input reads low so a gpio pin cannot disturb the cell
  always_comb begin
    firstInC  = (rowThreeAltFunction == dual_logic_pkg::ROW_THREE_LOGIC_C) ?
                rowThreePinIn : 1'b0;
    secondInC = columnSixAltFunction ? columnSixPinIn : 1'b0;
    secondInA = st_r.cfgTwo[dual_logic_pkg::CHAIN_BIT] ? firstY : secondInputA;
  end

  // ********************************************************************
  // logic cells
  // ********************************************************************
  // first block function
  logic_cell #(
    .STABLE_TICKS (STABLE_TICKS)
  ) firstCell (
    .clk            (clk),
    .resetn         (resetn),
    .funcSel        (st_r.cfgOne[dual_logic_pkg::SEL_MSB:dual_logic_pkg::SEL_LSB]),
    .invA           (st_r.cfgOne[dual_logic_pkg::INV_A_BIT]),
    .invB           (st_r.cfgOne[dual_logic_pkg::INV_B_BIT]),
    .invC           (st_r.cfgOne[dual_logic_pkg::INV_C_BIT]),
    .invY           (st_r.cfgOne[dual_logic_pkg::INV_Y_BIT]),
    .inA            (firstInputA),
    .inB            (firstInputB),
    .inC            (firstInC),
    .forceSet       (st_r.ffCtl[dual_logic_pkg::FIRST_FLIPFLOP_FORCE_SET_BIT]),
    .forceClear     (st_r.ffCtl[dual_logic_pkg::FF1_CLEAR_BIT]),
    .debounceBypass (st_r.evtEn[dual_logic_pkg::EV1_BYPASS_BIT]),
    .eventEnable    (st_r.evtEn[dual_logic_pkg::EV1_ENABLE_BIT]),
    .activeHigh     (st_r.evtEn[dual_logic_pkg::EV1_LEVEL_BIT]),
    .debounceTick   (st_r.tick),
    .blockOut       (firstY),
    .filteredOut    (firstFilt),
    .eventPulse     (firstEventPulse),
    .eventActive    (firstEventActive)
  );

  logic_cell #(
    .STABLE_TICKS (STABLE_TICKS)
  ) secondCell (
    .clk            (clk),
    .resetn         (resetn),
    .funcSel        (st_r.cfgTwo[dual_logic_pkg::SEL_MSB:dual_logic_pkg::SEL_LSB]),
    .invA           (st_r.cfgTwo[dual_logic_pkg::INV_A_BIT]),
    .invB           (st_r.cfgTwo[dual_logic_pkg::INV_B_BIT]),
    .invC           (st_r.cfgTwo[dual_logic_pkg::INV_C_BIT]),
    .invY           (st_r.cfgTwo[dual_logic_pkg::INV_Y_BIT]),
    .inA            (secondInA),
    .inB            (secondInputB),
    .inC            (secondInC),
    .forceSet       (st_r.ffCtl[dual_logic_pkg::SECOND_FLIPFLOP_FORCE_SET_BIT]),
    .forceClear     (st_r.ffCtl[dual_logic_pkg::FF2_CLEAR_BIT]),
    .debounceBypass (st_r.evtEn[dual_logic_pkg::EV2_BYPASS_BIT]),
    .eventEnable    (st_r.evtEn[dual_logic_pkg::EV2_ENABLE_BIT]),
    .activeHigh     (st_r.evtEn[dual_logic_pkg::EV2_LEVEL_BIT]),
    .debounceTick   (st_r.tick),
    .blockOut       (secondY),
    .filteredOut    (secondFilt),
    .eventPulse     (secondEventPulse),
    .eventActive    (secondEventActive)
  );

  // ********************************************************************
  // next-state logic
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;

    // debounce tick divider: one-cycle enable every TICK_CYCLES clocks
    if (st_r.divCount == DW'(TICK_CYCLES - 1)) begin
      st_nxt.divCount = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.divCount = st_r.divCount + DW'(1);
      st_nxt.tick     = 1'b0;
    end

    // register writes; reserved bits are not stored
    if (regWrEn) begin
      unique case (regAddr)
        dual_logic_pkg::ADDR_BLOCK_ONE_CFG: st_nxt.cfgOne = regWrData[6:0];
        dual_logic_pkg::ADDR_BLOCK_TWO_CFG: st_nxt.cfgTwo = regWrData;
        dual_logic_pkg::ADDR_FF_CONTROL:    st_nxt.ffCtl  = regWrData[3:0];
        dual_logic_pkg::ADDR_EVENT_ENABLE:  st_nxt.evtEn  = regWrData[5:0];
        default: ;
      endcase
    end

    // register reads answer one cycle later; unmapped offsets read zero
    st_nxt.rdValid = regRdEn;
    if (regRdEn) begin
      unique case (regAddr)
        dual_logic_pkg::ADDR_BLOCK_ONE_CFG: st_nxt.rdData = {1'b0, st_r.cfgOne};
        dual_logic_pkg::ADDR_BLOCK_TWO_CFG: st_nxt.rdData = st_r.cfgTwo;
        dual_logic_pkg::ADDR_FF_CONTROL:    st_nxt.rdData = {4'h0, st_r.ffCtl};
        dual_logic_pkg::ADDR_EVENT_ENABLE:  st_nxt.rdData = {2'h0, st_r.evtEn};
        default:                            st_nxt.rdData = 8'h00;
      endcase
    end

    st_nxt.rowZeroOut = rowZeroAltFunction ? firstY : 1'b0;
    st_nxt.rowZeroOeN = !rowZeroAltFunction;
    st_nxt.colNineOut = columnNineAltFunction ? secondY : 1'b0;
    st_nxt.colNineOeN = !columnNineAltFunction;
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  // pins released (enable high) from reset until software routes them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r.cfgOne     <= dual_logic_pkg::RESET_BLOCK_CFG[6:0];
      st_r.cfgTwo     <= dual_logic_pkg::RESET_BLOCK_CFG;
      st_r.ffCtl      <= dual_logic_pkg::RESET_FF_CONTROL;
      st_r.evtEn      <= dual_logic_pkg::RESET_EVENT_ENABLE;
      st_r.rdData     <= 8'h00;
      st_r.rdValid    <= 1'b0;
      st_r.divCount   <= '0;
      st_r.tick       <= 1'b0;
      st_r.rowZeroOut <= 1'b0;
      st_r.rowZeroOeN <= 1'b1;
      st_r.colNineOut <= 1'b0;
      st_r.colNineOeN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // pin outputs lag the logic by one clock, traded for glitch-free pins
  assign regRdData         = st_r.rdData;
  assign regRdValid        = st_r.rdValid;
  assign rowZeroPinOut     = st_r.rowZeroOut;
  assign rowZeroPinOeN     = st_r.rowZeroOeN;
  assign columnNinePinOut  = st_r.colNineOut;
  assign columnNinePinOeN  = st_r.colNineOeN;
  assign firstBlockOutput  = firstFilt;
  assign secondBlockOutput = secondFilt;

endmodule

`default_nettype wire

// ---- tb/dual_logic_chk.sv ----
// port assertions for the dual programmable logic block
`timescale 1ns/1ps
`default_nettype none
module dual_logic_chk #(
  parameter int TICK_CYCLES  = 200,
  parameter int STABLE_TICKS = 4
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] regAddr,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic       rowZeroAltFunction,
  input wire logic       columnNineAltFunction,
  input wire logic       rowZeroPinOut,
  input wire logic       rowZeroPinOeN,
  input wire logic       columnNinePinOut,
  input wire logic       columnNinePinOeN,
  input wire logic       firstBlockOutput,
  input wire logic       secondBlockOutput,
  input wire logic       firstEventPulse,
  input wire logic       secondEventPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****
  // register port
  // ****
  rd_valid_set_a: assert property (regRdEn |=> regRdValid)
    else $error("read valid missing");
  rd_valid_clr_a: assert property (!regRdEn |=> !regRdValid)
    else $error("stray read valid");
  unmapped_zero_a: assert property ((regRdEn && (regAddr < 8'h44 || regAddr > 8'h47))
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  ff_reserved_zero_a: assert property (regRdEn && regAddr == 8'h46 |=> regRdData[7:4] == 4'h0)
    else $error("flop control reserved bits set");
  // ****
  // pins and events
  // ****
  // pin released when not routed
  row_zero_free_a: assert property (!rowZeroAltFunction |=> rowZeroPinOeN && !rowZeroPinOut)
    else $error("row zero pin not released");
  row_zero_drive_a: assert property (rowZeroAltFunction |=> !rowZeroPinOeN)
    else $error("row zero pin not driven");
  col_nine_free_a: assert property (!columnNineAltFunction |=> columnNinePinOeN)
    else $error("column nine pin not released");
  ev_one_change_a: assert property (firstEventPulse |-> firstBlockOutput != $past(firstBlockOutput))
    else $error("first event without change");
  ev_two_change_a: assert property (secondEventPulse |-> secondBlockOutput != $past(secondBlockOutput))
    else $error("second event without change");
  cover property (firstEventPulse);
  cover property (secondEventPulse);
  cover property (regRdEn && regAddr == 8'h46 ##1 regRdValid);
  cover property (!rowZeroPinOeN && rowZeroPinOut);
endmodule

bind dual_programmable_logic dual_logic_chk #(
  .TICK_CYCLES(TICK_CYCLES), .STABLE_TICKS(STABLE_TICKS)
) u_chk (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regRdEn(regRdEn),
  .regRdData(regRdData), .regRdValid(regRdValid), .rowZeroAltFunction(rowZeroAltFunction),
  .columnNineAltFunction(columnNineAltFunction), .rowZeroPinOut(rowZeroPinOut),
  .rowZeroPinOeN(rowZeroPinOeN), .columnNinePinOut(columnNinePinOut),
  .columnNinePinOeN(columnNinePinOeN), .firstBlockOutput(firstBlockOutput),
  .secondBlockOutput(secondBlockOutput), .firstEventPulse(firstEventPulse),
  .secondEventPulse(secondEventPulse)
);
`default_nettype wire

// ---- tb/pin_model.sv ----
// pad model: external pin levels in, resolved output pin wires
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  input  wire logic       r0Out,
  input  wire logic       r0OeN,
  input  wire logic       c9Out,
  input  wire logic       c9OeN,
  output logic            rowThreePin,
  output logic            columnSixPin,
  output logic            rowZeroWire,
  output logic            columnNineWire
);
  logic r0Last = 1'b0;
  logic c9Last = 1'b0;
  // inputs straight from the bench levels
  assign rowThreePin  = level[1];
  assign columnSixPin = level[0];
  // no pull on these pads: a released pad flips each cycle, never holds the last value
  assign rowZeroWire    = r0OeN ? ~r0Last : r0Out;
  assign columnNineWire = c9OeN ? ~c9Last : c9Out;
  always_ff @(posedge clk) begin
    r0Last <= rowZeroWire;
    c9Last <= columnNineWire;
  end
endmodule
`default_nettype wire

// ---- tb/dual_programmable_logic_tb_top.sv ----
// self-checking bench for the dual programmable logic block
`timescale 1ns/1ps
`default_nettype none
module dual_programmable_logic_tb_top;
  logic       clk;
  logic       resetn;
  logic [7:0] addr;
  logic [7:0] wdat;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] rdat;
  logic       rdVal;
  logic [3:0] ins;
  logic [1:0] r3Alt;
  logic [2:0] alts;
  logic [1:0] lvl;
  logic       r3Pin, c6Pin, r0Out, r0OeN, c9Out, c9OeN, r0W, c9W;
  logic       y1, y2, p1, a1, p2, a2, e1, e2;
  logic [7:0] c1, c2, rdQ[$];
  logic [1:0] evQ[$];
  logic [31:0] seed = 32'hBE0494A5;
  int         num_errors = 0;
  int         checks = 0;
  localparam logic [17:0] FFT = {2'h0, 2'h3, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
  localparam logic [17:0] ABT = {2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
  localparam logic [8:0]  EXT = 9'b001011100;
  localparam logic [31:0] MSK = 32'h3F0FFF7F;

  dual_programmable_logic #(.TICK_CYCLES(4), .STABLE_TICKS(2)) u_dut (
    .clk(clk), .resetn(resetn), .regAddr(addr), .regWrData(wdat), .regWrEn(wrEn),
    .regRdEn(rdEn), .regRdData(rdat), .regRdValid(rdVal), .firstInputA(ins[3]),
    .firstInputB(ins[2]), .secondInputA(ins[1]), .secondInputB(ins[0]),
    .rowThreePinIn(r3Pin), .columnSixPinIn(c6Pin), .rowThreeAltFunction(r3Alt),
    .rowZeroAltFunction(alts[2]), .columnSixAltFunction(alts[1]),
    .columnNineAltFunction(alts[0]), .rowZeroPinOut(r0Out), .rowZeroPinOeN(r0OeN),
    .columnNinePinOut(c9Out), .columnNinePinOeN(c9OeN), .firstBlockOutput(y1),
    .secondBlockOutput(y2), .firstEventPulse(p1), .firstEventActive(a1),
    .secondEventPulse(p2), .secondEventActive(a2));
  pin_model u_pins (.clk(clk), .level(lvl), .r0Out(r0Out), .r0OeN(r0OeN), .c9Out(c9Out),
    .c9OeN(c9OeN), .rowThreePin(r3Pin), .columnSixPin(c6Pin), .rowZeroWire(r0W),
    .columnNineWire(c9W));

  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected output after inversion, from select and input inversion bits
  function automatic logic fn(input logic [7:0] cfg, input logic a, input logic b, input logic c);
    logic [2:0] v;
    logic       r;
    v = {c ^ cfg[5], b ^ cfg[4], a ^ cfg[3]};
    case (cfg[2:0])
      3'h1: r = &v;
      3'h2: r = |v;
      3'h3: r = ^v;
      3'h5: r = v[0];
      3'h6: r = v[1];
      3'h7: r = v[2];
      default: r = 1'b0;
    endcase
    return r ^ cfg[6];
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdat = d;
    wrEn = 1'b1;
    @(posedge clk) #1;
    wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    addr = a;
    rdEn = 1'b1;
    rdQ.push_back(exp);
    @(posedge clk) #1;
    rdEn = 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // result watcher: every read answer and event takes the oldest note
  always @(posedge clk) begin
    if (rdVal === 1'b1) begin
      if (rdQ.size() == 0) cmp(8'h01, 8'h00, "unexpected read");
      else cmp(rdat, rdQ.pop_front(), "read data");
    end
    if (p1 === 1'b1 || p2 === 1'b1) begin
      if (evQ.size() == 0) cmp(8'h01, 8'h00, "unexpected event");
      else cmp({6'h00, p2, p2 ? a2 : a1}, {6'h00, evQ.pop_front()}, "event");
    end
  end
  initial begin
    #100000;
    num_errors++;
    results();
  end

  // ****
  // tests
  // ****
  initial begin
    {addr, wdat, wrEn, rdEn, ins, r3Alt, alts, lvl} = '0;
    resetn = 1'b0;
    settle(5);
    resetn = 1'b1;
    cmp({6'h00, r0OeN, c9OeN}, 8'h03, "pins after reset");
    for (int i = 0; i < 4; i++) rd(8'h44 + 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h44 + 8'(i), 8'hFF);
      rd(8'h44 + 8'(i), MSK[8*i +: 8]);
      wr(8'h44 + 8'(i), 8'h00);
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h48, 8'h00);
    $display("register test done");
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      c1 = {1'b0, seed[6:0]};
      c2 = seed[15:8];
      if (c1[2:0] == 3'h4) c1[2:0] = 3'h3;
      if (c2[2:0] == 3'h4) c2[2:0] = 3'h1;
      wr(8'h44, c1);
      wr(8'h45, c2);
      {alts, r3Alt, lvl, ins} = seed[26:16];
      settle(3);
      e1 = fn(c1, ins[3], ins[2], r3Alt == 2'h1 && lvl[1]);
      e2 = fn(c2, c2[7] ? e1 : ins[1], ins[0], alts[1] && lvl[0]);
      cmp({7'h00, r0Out}, {7'h00, alts[2] & e1}, "row zero");
      cmp({7'h00, c9Out}, {7'h00, alts[0] & e2}, "column nine");
      cmp({6'h00, r0OeN, c9OeN}, {6'h00, ~alts[2], ~alts[0]}, "pin enables");
    end
    $display("function test done");
    {alts, r3Alt} = 5'h1C;
    for (int k = 0; k < 2; k++) begin
      wr(8'h44 + 8'(k), 8'h04);
      for (int s = 0; s < 9; s++) begin
        wr(8'h46, {4'h0, FFT[2*s +: 2]} << (2 * k));
        ins = {ABT[2*s +: 2], ABT[2*s +: 2]};
        settle(3);
        cmp({7'h00, k ? c9W : r0W}, {7'h00, EXT[s]}, "flop");
      end
    end
    $display("flop test done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h47, 8'h00);
      wr(8'h44 + 8'(k), 8'h05);
      ins = 4'h0;
      settle(40);
      // bypass, events on, high then low active level, then events off
      for (int m = 0; m < 3; m++) begin
        wr(8'h47, 8'((m == 0 ? 7 : m == 1 ? 6 : 4) << (3 * k)));
        if (m < 2) evQ.push_back({k[0], m == 0});
        ins[3 - 2*k] = 1'b1;
        settle(3);
        if (m < 2) evQ.push_back({k[0], m == 1});
        ins[3 - 2*k] = 1'b0;
        settle(3);
      end
      // debounced: a one-cycle glitch is dropped, a held change comes through
      wr(8'h47, 8'(3 << (3 * k)));
      ins[3 - 2*k] = 1'b1;
      settle(1);
      ins[3 - 2*k] = 1'b0;
      settle(40);
      evQ.push_back({k[0], 1'b1});
      ins[3 - 2*k] = 1'b1;
      settle(40);
      cmp({7'h00, k ? y2 : y1}, 8'h01, "filtered high");
      // select off drops the output with no event
      wr(8'h44 + 8'(k), 8'h00);
      settle(40);
      cmp({7'h00, k ? y2 : y1}, 8'h00, "filtered off");
      cmp(8'(evQ.size()), 8'h00, "events outstanding");
    end
    wr(8'h47, 8'h00);
    $display("event test done");
    settle(4);
    results();
  end
endmodule
`default_nettype wire
